// >>> logic/housekeeping_status_regs.sv
// Housekeeping status and identification registers behind the command port.
// Assumes a front end that decodes each bus command into one cmd_valid strobe.
//
// What this block does
// - Fixed read-only identification word, writes refused.
// - Read-only factory lot byte per page.
// - Refresh ECC word on every EEPROM load.
// - ECC user flag one means no corrections.
// - Undischarged turn-on sets status, pulls alert low.
// - Hold channel off until output falls below threshold.
// - Coefficient above one disables discharge check.
// - Coefficient is sixteen-bit L11 value.
// - Common status readable even while busy.
// - Busy device NACKs other commands, flags busy.
// - Status bit 7 shows alert pin level.
// - Status bit 6 high when ready.
// - Status bits 5 to 2 read ones.
// - Status bit 1 high when share clock stuck low.
// - Status bit 0 mirrors write-protect pin.
// - Scratchpad words stored and restored via EEPROM.
// - Twenty user bytes: two words plus eight paged.
// - Track lowest measured output voltage per channel.
// - Minimum resets on reset, clear, turn-on.
// - Minimum unsupported on odd current-sense channels.
// - Minimum frozen while undervoltage detection disabled.
`timescale 1ns/100ps
module housekeeping_status_regs #(
    parameter int NCH = hk_pkg::NCH,
    parameter logic [15:0] ID_WORD = 16'h5A5A, // Arbitrary value
    parameter logic [8*NCH-1:0] LOT_CODES = 64'h1716151413121110 // Arbitrary values
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    input hk_pkg::cmd_t cmd,
    output logic rsp_valid,
    output hk_pkg::rsp_t rsp,
    output logic busy_nack,
    input wire logic dev_busy,
    // EEPROM engine
    output logic ee_restore_req,
    output hk_pkg::ee_word_t ee_store,
    input hk_pkg::ee_word_t ee_load,
    input wire logic ee_read_done,
    input wire logic ee_ecc_user_clean,
    // Channels
    input wire logic [NCH-1:0] chan_on_cmd,
    input wire logic [NCH-1:0][15:0] vout_command,
    input hk_pkg::adc_t adc,
    input wire logic [NCH-1:0] uv_enable,
    input wire logic [NCH-1:0] meas_current,
    output logic [NCH-1:0] chan_on,
    output logic [NCH-1:0] discharge_status,
    // Pins
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe_n,
    input wire logic share_clk_in,
    input wire logic wp_in
);
    logic alert_meta, alert_s, wp_meta, wp_s, shc_meta, shc_s, shc_d;
    logic [4:0] idle_cnt;
    logic shclk_held;
    logic [NCH-1:0][15:0] coef;
    logic [NCH-1:0][15:0] vout_meas;
    logic [NCH-1:0][15:0] min_vout;
    logic [15:0] scratch [hk_pkg::SCR_WORDS];
    logic [15:0] ecc_info;
    hk_pkg::chan_st_t ch_st [NCH];
    logic [NCH-1:0] allowed, to_on, blocked, clr_page;
    hk_pkg::rsp_t next_rsp;
    logic next_busy;
    logic wr_ok;
    logic store_act;
    logic [3:0] store_idx;
    logic [7:0] common_byte;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Coefficient above 1.0, from L11 mantissa and exponent
    function automatic logic coef_gt_one(input logic [15:0] c);
        logic [10:0] m;
        logic [4:0] e;
        m = c[10:0];
        e = c[15:11];
        if (m[10]) return 1'b0;
        if (!e[4]) return (m > 11'd1) || (m == 11'd1 && e != 5'd0);
        return 27'(m) > (27'd1 << (5'd0 - e));
    endfunction

    // Output at or above coefficient times commanded voltage
    function automatic logic at_or_above(input logic [15:0] meas, input logic [15:0] vcmd,
                                         input logic [15:0] c);
        logic [47:0] lhs, rhs;
        logic [4:0] e;
        e = c[15:11];
        if (c[10]) return 1'b1;
        lhs = 48'(meas);
        rhs = 48'(c[10:0]) * 48'(vcmd);
        if (e[4]) lhs = lhs << (5'd0 - e);
        else rhs = rhs << e;
        return lhs >= rhs;
    endfunction

    // Pin synchronisers; the second stage is read, and the share clock also has a third stage for edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {alert_meta, alert_s} <= 2'b11;
            {wp_meta, wp_s} <= 2'b00;
            {shc_meta, shc_s, shc_d} <= 3'b000;
        end else begin
            {alert_meta, alert_s} <= {alert_in, alert_meta};
            {wp_meta, wp_s} <= {wp_in, wp_meta};
            {shc_meta, shc_s, shc_d} <= {share_clk_in, shc_meta, shc_s};
        end
    end

    // Share clock watchdog: no edge for the idle time while low means held
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_cnt <= 5'h00;
            shclk_held <= 1'b0;
        end else begin
            if (shc_s != shc_d) idle_cnt <= 5'h00;
            else if (idle_cnt != hk_pkg::SHCLK_IDLE_CNT) idle_cnt <= idle_cnt + 5'h01;
            shclk_held <= (idle_cnt == hk_pkg::SHCLK_IDLE_CNT) && !shc_s;
        end
    end

    // Status byte assembled from live state so it never waits on the busy engine
    always_comb begin
        common_byte = 8'h00;
        common_byte[hk_pkg::COM_ALERT] = alert_s;
        common_byte[hk_pkg::COM_READY] = !dev_busy;
        common_byte[5:2] = hk_pkg::COM_RSVD;
        common_byte[hk_pkg::COM_SHCLK] = shclk_held;
        common_byte[hk_pkg::COM_WP] = wp_s;
    end

    // Turn-on gating per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            allowed[i] = chan_on_cmd[i] && (coef_gt_one(coef[i])
                         || !at_or_above(vout_meas[i], vout_command[i], coef[i]));
            to_on[i] = allowed[i] && ch_st[i] != hk_pkg::CH_ON;
            blocked[i] = chan_on_cmd[i] && !allowed[i] && ch_st[i] == hk_pkg::CH_OFF;
            clr_page[i] = wr_ok && cmd.code == hk_pkg::CMD_CLEAR_FAULTS && cmd.page == 3'(i);
        end
    end

    // Command decode
    always_comb begin
        next_rsp.nack = 1'b0;
        next_rsp.data = 16'h0000;
        next_busy = 1'b0;
        if (dev_busy && cmd.code != hk_pkg::CMD_COMMON) begin
            next_rsp.nack = 1'b1;
            next_busy = 1'b1;
        end else if (cmd.code == hk_pkg::CMD_COMMON) begin
            next_rsp.nack = cmd.write;
            next_rsp.data = {8'h00, common_byte};
        end else if (cmd.code == hk_pkg::CMD_ID) begin
            next_rsp.nack = cmd.write;
            next_rsp.data = ID_WORD;
        end else if (cmd.code == hk_pkg::CMD_LOT) begin
            next_rsp.nack = cmd.write;
            next_rsp.data = {8'h00, LOT_CODES[cmd.page*8 +: 8]};
        end else if (cmd.code == hk_pkg::CMD_INFO) begin
            next_rsp.nack = cmd.write;
            next_rsp.data = ecc_info;
        end else if (cmd.code == hk_pkg::CMD_DISCH) begin
            next_rsp.data = coef[cmd.page];
        end else if (cmd.code == hk_pkg::CMD_VOUT_MIN) begin
            next_rsp.nack = cmd.write || (cmd.page[0] && meas_current[cmd.page]);
            next_rsp.data = min_vout[cmd.page];
        end else if (cmd.code == hk_pkg::CMD_USER_OEM) begin
            next_rsp.data = scratch[hk_pkg::SCR_OEM];
        end else if (cmd.code == hk_pkg::CMD_USER_WORD) begin
            next_rsp.data = scratch[hk_pkg::SCR_USER];
        end else if (cmd.code == hk_pkg::CMD_USER_PAGED) begin
            next_rsp.data = scratch[hk_pkg::SCR_PAGED + int'(cmd.page)];
        end else if (cmd.code == hk_pkg::CMD_CLEAR_FAULTS || cmd.code == hk_pkg::CMD_STORE_ALL
                     || cmd.code == hk_pkg::CMD_RESTORE_ALL) begin
            next_rsp.nack = !cmd.write;
        end else begin
            next_rsp.nack = 1'b1;
        end
    end

    assign wr_ok = cmd_valid && cmd.write && !next_rsp.nack;

    // Answer one cycle after each command
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
            busy_nack <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid;
            rsp <= cmd_valid ? next_rsp : '0;
            busy_nack <= cmd_valid && next_busy;
        end
    end

    // Discharge coefficients and latest readings
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            coef <= {NCH{hk_pkg::COEF_RESET}};
            vout_meas <= '0;
        end else begin
            if (wr_ok && cmd.code == hk_pkg::CMD_DISCH) coef[cmd.page] <= cmd.data;
            if (adc.valid) vout_meas[adc.chan] <= adc.vout;
        end
    end

    // Channel sequencing: a blocked request waits, dropping the request turns off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) ch_st[i] <= hk_pkg::CH_OFF;
            chan_on <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                case (ch_st[i])
                    hk_pkg::CH_ON: begin
                        if (!chan_on_cmd[i]) ch_st[i] <= hk_pkg::CH_OFF;
                    end
                    default: begin
                        if (!chan_on_cmd[i]) ch_st[i] <= hk_pkg::CH_OFF;
                        else if (allowed[i]) ch_st[i] <= hk_pkg::CH_ON;
                        else ch_st[i] <= hk_pkg::CH_WAIT;
                    end
                endcase
                chan_on[i] <= chan_on_cmd[i] && (allowed[i] || ch_st[i] == hk_pkg::CH_ON);
            end
        end
    end

    // Discharge status: a new block wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            discharge_status <= '0;
            alert_oe_n <= 1'b1;
            alert_out <= 1'b0;
        end else begin
            discharge_status <= blocked | (discharge_status & ~clr_page);
            alert_oe_n <= ~|discharge_status;
            alert_out <= 1'b0;
        end
    end

    // ECC word follows every completed EEPROM load
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ecc_info <= hk_pkg::ECC_INFO_RESET;
        end else if (ee_read_done) begin
            ecc_info <= 16'h0000;
            ecc_info[hk_pkg::ECC_USER_BIT] <= ee_ecc_user_clean;
        end
    end

    // Scratchpad: EEPROM reload, then host writes take precedence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < hk_pkg::SCR_WORDS; i++) scratch[i] <= 16'h0000;
        end else begin
            if (ee_load.valid && ee_load.index <= hk_pkg::SCR_LAST)
                scratch[ee_load.index] <= ee_load.word;
            if (wr_ok && cmd.code == hk_pkg::CMD_USER_OEM)
                scratch[hk_pkg::SCR_OEM] <= cmd.data;
            if (wr_ok && cmd.code == hk_pkg::CMD_USER_WORD)
                scratch[hk_pkg::SCR_USER] <= cmd.data;
            if (wr_ok && cmd.code == hk_pkg::CMD_USER_PAGED)
                scratch[hk_pkg::SCR_PAGED + int'(cmd.page)] <= cmd.data;
        end
    end

    // Store streams all scratch words out, one per cycle; restore asks the engine
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            store_act <= 1'b0;
            store_idx <= 4'h0;
            ee_store <= '0;
            ee_restore_req <= 1'b0;
        end else begin
            ee_restore_req <= wr_ok && cmd.code == hk_pkg::CMD_RESTORE_ALL;
            if (store_act) begin
                ee_store <= '{valid: 1'b1, index: store_idx, word: scratch[store_idx]};
                store_idx <= store_idx + 4'h1;
                if (store_idx == hk_pkg::SCR_LAST) store_act <= 1'b0;
            end else begin
                ee_store <= '0;
                if (wr_ok && cmd.code == hk_pkg::CMD_STORE_ALL) begin
                    store_act <= 1'b1;
                    store_idx <= 4'h0;
                end
            end
        end
    end

    vout_min_tracker #(.NCH(NCH)) u_min (
        .core_clk(core_clk),
        .rst(rst),
        .adc(adc),
        .uv_enable(uv_enable),
        .meas_current(meas_current),
        .reset_min(to_on | clr_page),
        .min_vout(min_vout)
    );

    sequence s_read(logic [7:0] op_code);
        cmd_valid && !cmd.write && cmd.code == op_code && !dev_busy;
    endsequence
    sequence s_common_read;
        cmd_valid && !cmd.write && cmd.code == hk_pkg::CMD_COMMON;
    endsequence

    property p_id_fixed;
        s_read(hk_pkg::CMD_ID) |=> rsp_valid && !rsp.nack && rsp.data == ID_WORD;
    endproperty
    a_id_fixed: assert property (p_id_fixed) else $error("id word wrong");

    property p_busy_nack;
        cmd_valid && dev_busy && cmd.code != hk_pkg::CMD_COMMON |=> rsp.nack && busy_nack;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("busy command not refused");

    property p_common_busy;
        s_common_read |=> rsp_valid && !rsp.nack;
    endproperty
    a_common_busy: assert property (p_common_busy) else $error("status read refused");

    property p_common_rsvd;
        s_common_read |=> rsp.data[5:2] == 4'hF && rsp.data[6] == !$past(dev_busy);
    endproperty
    a_common_rsvd: assert property (p_common_rsvd) else $error("status bits wrong");

    property p_wp_mirror;
        s_common_read |=> rsp.data[0] == $past(wp_s) && rsp.data[7] == $past(alert_s);
    endproperty
    a_wp_mirror: assert property (p_wp_mirror) else $error("pin bits wrong");

    property p_disch_set;
        blocked[2] |=> discharge_status[2] ##1 !alert_oe_n;
    endproperty
    a_disch_set: assert property (p_disch_set) else $error("discharge not flagged");

    property p_hold_off;
        chan_on_cmd[2] && !allowed[2] && ch_st[2] != hk_pkg::CH_ON |=> !chan_on[2];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("channel on too early");

    property p_gt_one_free;
        chan_on_cmd[3] && coef_gt_one(coef[3]) |=> chan_on[3];
    endproperty
    a_gt_one_free: assert property (p_gt_one_free) else $error("check not disabled");

    property p_min_turn_on;
        $rose(chan_on[2]) |-> min_vout[2] == hk_pkg::MIN_RESET;
    endproperty
    a_min_turn_on: assert property (p_min_turn_on) else $error("minimum not reset");
endmodule // housekeeping_status_regs

// >>> logic/hk_pkg.sv
// Shared constants and carrier types for the housekeeping register block.
// Assumes one core clock at 25 MHz and a parsed command front end.
package hk_pkg;
    localparam int NCH = 8;
    // Timing
    localparam int CLK_NS = 40;
    localparam int SHCLK_IDLE_NS = 1000;
    localparam int SHCLK_IDLE_CYC = (SHCLK_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] SHCLK_IDLE_CNT = 5'(SHCLK_IDLE_CYC);
    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
    localparam logic [7:0] CMD_USER_OEM = 8'hB2;
    localparam logic [7:0] CMD_USER_WORD = 8'hB3;
    localparam logic [7:0] CMD_USER_PAGED = 8'hB4;
    localparam logic [7:0] CMD_ID = 8'hE7;
    localparam logic [7:0] CMD_LOT = 8'hE8;
    localparam logic [7:0] CMD_INFO = 8'hE9;
    localparam logic [7:0] CMD_DISCH = 8'hEA;
    localparam logic [7:0] CMD_COMMON = 8'hEB;
    localparam logic [7:0] CMD_VOUT_MIN = 8'hEC;
    // Reset values and fields
    localparam logic [15:0] MIN_RESET = 16'hFFFF;
    localparam logic [15:0] COEF_RESET = 16'h0002;
    localparam logic [15:0] ECC_INFO_RESET = 16'h0020;
    localparam int ECC_USER_BIT = 5;
    localparam int COM_ALERT = 7;
    localparam int COM_READY = 6;
    localparam int COM_SHCLK = 1;
    localparam int COM_WP = 0;
    localparam logic [3:0] COM_RSVD = 4'hF;
    // Scratchpad layout
    localparam int SCR_WORDS = 10;
    localparam int SCR_OEM = 0;
    localparam int SCR_USER = 1;
    localparam int SCR_PAGED = 2;
    localparam logic [3:0] SCR_LAST = 4'h9;

    typedef enum logic [1:0] {CH_OFF = 2'b00, CH_WAIT = 2'b01, CH_ON = 2'b10} chan_st_t;
    typedef struct packed {
        logic write;
        logic [2:0] page;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_t;
    typedef struct packed {
        logic nack;
        logic [15:0] data;
    } rsp_t;
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [15:0] word;
    } ee_word_t;
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [15:0] vout;
    } adc_t;
endpackage

// >>> logic/vout_min_tracker.sv
// Per-channel minimum output voltage tracker.
// Assumes ADC results arrive as single-cycle valid strobes on core_clk.
`timescale 1ns/100ps
module vout_min_tracker #(
    parameter int NCH = hk_pkg::NCH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // ADC results and channel conditions
    input hk_pkg::adc_t adc,
    input wire logic [NCH-1:0] uv_enable,
    input wire logic [NCH-1:0] meas_current,
    input wire logic [NCH-1:0] reset_min,
    // Tracked minima
    output logic [NCH-1:0][15:0] min_vout
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Reset pulses win over a reading in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            min_vout <= {NCH{hk_pkg::MIN_RESET}};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (reset_min[i]) begin
                    min_vout[i] <= hk_pkg::MIN_RESET;
                end else if (adc.valid && adc.chan == 3'(i) && uv_enable[i]
                             && !(i % 2 == 1 && meas_current[i])
                             && adc.vout < min_vout[i]) begin
                    min_vout[i] <= adc.vout;
                end
            end
        end
    end

    property p_min_no_rise;
        !reset_min[2] |=> min_vout[2] <= $past(min_vout[2]);
    endproperty
    a_min_no_rise: assert property (p_min_no_rise) else $error("minimum rose");

    property p_uv_hold;
        !uv_enable[2] && !reset_min[2] |=> $stable(min_vout[2]);
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("minimum moved with UV off");
endmodule // vout_min_tracker

// >>> test/hk_host_model.sv
// Host side model: sends one decoded bus command at a time and returns the answer.
// Assumes the block answers exactly one core_clk cycle after it takes a command.
`timescale 1ns/100ps
module hk_host_model (
    // Clock
    input wire logic core_clk,
    // Command side
    output logic cmd_valid,
    output hk_pkg::cmd_t cmd,
    input wire logic rsp_valid,
    input hk_pkg::rsp_t rsp,
    input wire logic busy_nack
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // Any code may be sent at any time, so the status byte can be polled while busy
    task automatic xfer(input logic wr, input logic [2:0] pg, input logic [7:0] code,
                        input logic [15:0] wd, output hk_pkg::rsp_t r, output logic bn);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd = '{wr, pg, code, wd};
        @(posedge core_clk);
        #1;
        r = rsp_valid ? rsp : 'x;
        bn = busy_nack;
        cmd_valid = 1'b0;
        cmd = ~cmd; // Released bus no longer holds the request
    endtask
endmodule // hk_host_model

// >>> test/housekeeping_status_regs_tb_top.sv
// Self-checking bench for the housekeeping register block.
// Assumes the host model drives the command port; pins and engine are driven here.
`timescale 1ns/100ps
module housekeeping_status_regs_tb_top;
    localparam logic [15:0] ID_W = 16'h2C2C; // Arbitrary value
    localparam logic [63:0] LOTS = 64'hA7A6A5A4A3A2A1A0;
    logic core_clk, rst, cmd_valid, rsp_valid, busy_nack, dev_busy, ee_restore_req, bn, seen;
    logic ee_read_done, ee_ecc_user_clean, alert_in, alert_out, alert_oe_n;
    logic share_clk_in, wp_in, sh_run;
    logic [7:0] chan_on_cmd, uv_enable, meas_current, chan_on, discharge_status;
    logic [7:0][15:0] vout_command;
    hk_pkg::cmd_t cmd;
    hk_pkg::rsp_t rsp, r;
    hk_pkg::ee_word_t ee_store, ee_load;
    hk_pkg::adc_t adc;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;

    hk_host_model i_hk_host_model (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .busy_nack(busy_nack));
    housekeeping_status_regs #(.ID_WORD(ID_W), .LOT_CODES(LOTS)) i_housekeeping_status_regs (
        .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .busy_nack(busy_nack), .dev_busy(dev_busy),
        .ee_restore_req(ee_restore_req), .ee_store(ee_store), .ee_load(ee_load),
        .ee_read_done(ee_read_done), .ee_ecc_user_clean(ee_ecc_user_clean),
        .chan_on_cmd(chan_on_cmd), .vout_command(vout_command), .adc(adc),
        .uv_enable(uv_enable), .meas_current(meas_current), .chan_on(chan_on),
        .discharge_status(discharge_status), .alert_in(alert_in), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .share_clk_in(share_clk_in), .wp_in(wp_in));

    // Alert wire has a pull-up, so it is high whenever nobody drives it
    assign alert_in = alert_oe_n ? 1'b1 : alert_out;

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Share clock is unrelated in phase and rests low when stopped
    initial begin
        share_clk_in = 1'b0;
        #7;
        forever #160 share_clk_in = sh_run ? ~share_clk_in : 1'b0;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic op(input logic wr, input logic [2:0] pg, input logic [7:0] c,
                      input logic [15:0] d);
        i_hk_host_model.xfer(wr, pg, c, d, r, bn);
    endtask
    task automatic adc_put(input logic [2:0] ch, input logic [15:0] v);
        adc = '{1'b1, ch, v};
        tick(1);
        adc.valid = 1'b0;
        tick(1);
    endtask

    task automatic t_ident;
        op(0, 0, hk_pkg::CMD_ID, 16'h0000);
        chk("id", r.data, ID_W);
        op(1, 0, hk_pkg::CMD_ID, 16'h1111);
        chk("id_write_nack", r.nack, 1'b1);
        op(0, 0, hk_pkg::CMD_ID, 16'h0000);
        chk("id_kept", r.data, ID_W);
        for (int p = 0; p < 8; p++) begin
            op(0, 3'(p), hk_pkg::CMD_LOT, 16'h0000);
            chk("lot", r.data, {8'h00, LOTS[8*p+:8]});
        end
        op(1, 3, hk_pkg::CMD_LOT, 16'h0055);
        chk("lot_write_nack", r.nack, 1'b1);
        $display("test ident done");
    endtask

    task automatic t_common;
        wp_in = 1'b1;
        tick(40);
        op(0, 0, hk_pkg::CMD_COMMON, 16'h0000);
        chk("common_idle", r.data, 16'h00FF);
        wp_in = 1'b0;
        sh_run = 1'b1;
        tick(30);
        op(0, 0, hk_pkg::CMD_COMMON, 16'h0000);
        chk("common_run", r.data, 16'h00FC);
        dev_busy = 1'b1;
        tick(2);
        op(0, 0, hk_pkg::CMD_COMMON, 16'h0000);
        chk("common_busy", {bn, r.nack, r.data[7:0]}, 16'h00BC);
        op(0, 0, hk_pkg::CMD_ID, 16'h0000);
        chk("busy_refuse", {bn, r.nack}, 16'h0003);
        dev_busy = 1'b0;
        $display("test common done");
    endtask

    task automatic t_eeprom;
        ee_ecc_user_clean = 1'b0;
        ee_read_done = 1'b1;
        tick(1);
        ee_read_done = 1'b0;
        tick(2);
        op(0, 0, hk_pkg::CMD_INFO, 16'h0000);
        chk("ecc_fixed", r.data, 16'h0000);
        op(1, 0, hk_pkg::CMD_RESTORE_ALL, 16'h0000);
        seen = ee_restore_req;
        repeat (3) begin
            tick(1);
            seen = seen | ee_restore_req;
        end
        chk("restore_req", seen, 1'b1);
        ee_load = '{1'b1, 4'h2, 16'h1234};
        ee_ecc_user_clean = 1'b1;
        ee_read_done = 1'b1;
        tick(1);
        ee_load.valid = 1'b0;
        ee_read_done = 1'b0;
        tick(2);
        op(0, 0, hk_pkg::CMD_INFO, 16'h0000);
        chk("ecc_clean", r.data, 16'h0020);
        op(0, 0, hk_pkg::CMD_USER_PAGED, 16'h0000);
        chk("restored", r.data, 16'h1234);
        op(1, 7, hk_pkg::CMD_USER_PAGED, 16'hBEEF);
        op(1, 0, hk_pkg::CMD_USER_WORD, 16'h0B0B);
        op(1, 0, hk_pkg::CMD_USER_OEM, 16'h0E0E);
        op(1, 0, hk_pkg::CMD_STORE_ALL, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            tick(1);
            chk("store_word", {ee_store.valid, 3'h0, ee_store.index, 8'h00},
                {4'h8, 4'(i), 8'h00});
            chk("store_data", ee_store.word, i == 0 ? 16'h0E0E : i == 1 ? 16'h0B0B :
                i == 2 ? 16'h1234 : i == 9 ? 16'hBEEF : 16'h0000);
        end
        tick(1);
        chk("store_end", ee_store.valid, 1'b0);
        $display("test eeprom done");
    endtask

    task automatic t_channels;
        vout_command[2] = 16'h2000;
        vout_command[3] = 16'h2000;
        op(1, 2, hk_pkg::CMD_DISCH, 16'hF801);
        op(0, 2, hk_pkg::CMD_DISCH, 16'h0000);
        chk("coef", r.data, 16'hF801);
        adc_put(2, 16'h1800);
        chan_on_cmd[2] = 1'b1;
        tick(3);
        chk("blocked", {chan_on[2], discharge_status[2], alert_oe_n, alert_out}, 16'h0004);
        tick(3);
        op(0, 0, hk_pkg::CMD_COMMON, 16'h0000);
        chk("alert_bit", r.data[7], 1'b0);
        adc_put(2, 16'h0800);
        tick(1);
        chk("turned_on", chan_on[2], 1'b1);
        op(0, 2, hk_pkg::CMD_VOUT_MIN, 16'h0000);
        chk("min_on", r.data, 16'hFFFF);
        adc_put(2, 16'h0900);
        adc_put(2, 16'h0A00);
        uv_enable[2] = 1'b0;
        adc_put(2, 16'h0100);
        op(0, 2, hk_pkg::CMD_VOUT_MIN, 16'h0000);
        chk("min_track", r.data, 16'h0900);
        uv_enable[2] = 1'b1;
        op(1, 2, hk_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        tick(2);
        chk("cleared", {discharge_status[2], alert_oe_n}, 16'h0001);
        op(0, 2, hk_pkg::CMD_VOUT_MIN, 16'h0000);
        chk("min_clear", r.data, 16'hFFFF);
        op(0, 3, hk_pkg::CMD_DISCH, 16'h0000);
        chk("coef_reset", r.data, 16'h0002);
        adc_put(3, 16'hF000);
        chan_on_cmd[3] = 1'b1;
        tick(2);
        chk("no_check", {chan_on[3], discharge_status[3]}, 16'h0002);
        meas_current[3] = 1'b1;
        op(0, 3, hk_pkg::CMD_VOUT_MIN, 16'h0000);
        chk("min_current", r.nack, 1'b1);
        adc_put(3, 16'h0010);
        meas_current[3] = 1'b0;
        op(0, 3, hk_pkg::CMD_VOUT_MIN, 16'h0000);
        chk("min_cur_frozen", r.data, 16'hFFFF);
        $display("test channels done");
    endtask

    initial begin
        rst = 1'b1;
        dev_busy = 1'b0;
        ee_load = '0;
        ee_read_done = 1'b0;
        ee_ecc_user_clean = 1'b1;
        chan_on_cmd = '0;
        vout_command = '0;
        adc = '0;
        uv_enable = '1;
        meas_current = '0;
        wp_in = 1'b0;
        sh_run = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_ident();
        t_common();
        t_eeprom();
        t_channels();
        complete_run();
    end
endmodule // housekeeping_status_regs_tb_top
